// file: amp_cfg_pkg.sv
package amp_cfg_pkg;
  localparam int         NUM_RF       = 12;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_THR      = 8'h01;
  localparam logic [7:0] REG_PRE      = 8'h02;
  localparam logic [7:0] REG_RATE_C   = 8'h06;
  localparam logic [7:0] REG_RATE_D   = 8'h07;
  localparam logic [7:0] REG_LOSS_A   = 8'h08;
  localparam logic [7:0] REG_LOSS_B   = 8'h09;
  localparam logic [7:0] REG_LOSS_C   = 8'h0A;
  localparam logic [7:0] REG_LOSS_D   = 8'h0B;
  localparam logic [7:0] REG_ACT_RATE = 8'h0E;
  localparam logic [7:0] REG_ACT_LOSS = 8'h0F;
  localparam logic [7:0] MSK_CTRL     = 8'h0F;
  localparam logic [7:0] MSK_THR      = 8'hFF;
  localparam logic [7:0] MSK_PRE      = 8'h0F;
  localparam logic [7:0] MSK_RATE     = 8'h8F;
  localparam logic [7:0] MSK_LOSS     = 8'hFF;
  localparam logic [7:0] MSK_NONE     = 8'h00;
  localparam int         USE_BIT      = 7;
  localparam int         OFF_BIT      = 3;
  localparam int         RNG_BIT      = 2;
  localparam int         OCO_BIT      = 1;
  localparam int         SIO_BIT      = 0;
  localparam logic [7:0] RST_THR      = 8'h80;
  localparam logic [7:0] THR_ZERO     = 8'h80;
  localparam logic [7:0] THR_NONE     = 8'h00;
  localparam logic [6:0] THR_MAX_MAG  = 7'h7F;
  localparam logic [3:0] DEF_RATE_A   = 4'h1;
  localparam logic [3:0] DEF_RATE_B   = 4'h6;
  localparam logic [3:0] DEF_RATE_C   = 4'h8;
  localparam logic [3:0] DEF_RATE_D   = 4'hF;
  localparam logic [6:0] DEF_LOSS     = 7'h00;
  localparam logic [1:0] PIN_A        = 2'b00;
  localparam logic [1:0] PIN_B        = 2'b01;
  localparam logic [1:0] PIN_C        = 2'b11;
  localparam logic [1:0] PIN_D        = 2'b10;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SERVE = 2'b10
  } xfer_e;
endpackage

// file: amp_xfer_if.sv
`timescale 1ns/1ps
interface amp_xfer_if;
  logic       req_tgl;
  logic       write;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       ack_tgl;
  logic [7:0] rdata;
  modport link (output req_tgl, write, addr, wdata, input ack_tgl, rdata);
  modport core (input req_tgl, write, addr, wdata, output ack_tgl, rdata);
endinterface

// file: amp_link_port.sv
`timescale 1ns/1ps
module amp_link_port
  import amp_cfg_pkg::*;
(
  input  wire logic       i_link_clk,
  input  wire logic       i_link_nrst,
  input  wire logic       i_xfer_valid,
  input  wire logic       i_xfer_write,
  input  wire logic [7:0] i_xfer_addr,
  input  wire logic [7:0] i_xfer_wdata,
  output logic            o_xfer_busy,
  output logic            o_xfer_done,
  output logic [7:0]      o_xfer_rdata,
  amp_xfer_if.link        xf
);
  typedef struct packed {
    logic       req;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       ack_s1;
    logic       ack_s2;
    logic       busy;
    logic       done;
    logic [7:0] rdata;
  } link_s;

  link_s q_r;
  link_s q_nxt;

  // Words stay frozen while busy, so the core may sample them freely
  always_comb begin
    q_nxt        = q_r;
    q_nxt.ack_s1 = xf.ack_tgl;
    q_nxt.ack_s2 = q_r.ack_s1;
    q_nxt.done   = 1'b0;
    if (q_r.busy && (q_r.ack_s2 == q_r.req)) begin
      q_nxt.busy  = 1'b0;
      q_nxt.done  = 1'b1;
      q_nxt.rdata = xf.rdata;
    end else if (!q_r.busy && i_xfer_valid) begin
      q_nxt.req   = ~q_r.req;
      q_nxt.wr    = i_xfer_write;
      q_nxt.addr  = i_xfer_addr;
      q_nxt.wdata = i_xfer_wdata;
      q_nxt.busy  = 1'b1;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!i_link_nrst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign xf.req_tgl   = q_r.req;
  assign xf.write     = q_r.wr;
  assign xf.addr      = q_r.addr;
  assign xf.wdata     = q_r.wdata;
  assign o_xfer_busy  = q_r.busy;
  assign o_xfer_done  = q_r.done;
  assign o_xfer_rdata = q_r.rdata;

  // Core samples these words unsynchronised, so they must hold until the ack
  property p_link_hold;
    @(posedge i_link_clk) disable iff (!i_link_nrst)
      (q_r.busy && (q_r.ack_s2 != q_r.req))
        |=> $stable(q_r.addr) && $stable(q_r.wdata) && $stable(q_r.wr);
  endproperty
  a_link_hold : assert property (p_link_hold)
    else $error("link words changed during a pending transfer");
endmodule

// file: amp_config_register_bank.sv
`timescale 1ns/1ps
module amp_config_register_bank
  import amp_cfg_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_clk_en,
  input  wire logic       i_rate_pin_high,
  input  wire logic       i_rate_pin_low,
  input  wire logic       i_link_clk,
  input  wire logic       i_link_nrst,
  input  wire logic       i_xfer_valid,
  input  wire logic       i_xfer_write,
  input  wire logic [7:0] i_xfer_addr,
  input  wire logic [7:0] i_xfer_wdata,
  output logic            o_xfer_busy,
  output logic            o_xfer_done,
  output logic [7:0]      o_xfer_rdata,
  output logic            o_output_off_flag,
  output logic            o_detector_range_flag,
  output logic            o_offset_correction_off,
  output logic            o_serial_interface_off,
  output logic            o_shift_negative,
  output logic [6:0]      o_shift_magnitude,
  output logic [3:0]      o_preemphasis_code,
  output logic [3:0]      o_active_rate_value,
  output logic [6:0]      o_active_loss_value
);
  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    xfer_e           st;
    logic            req_s1;
    logic            req_s2;
    logic            req_seen;
    logic            ack;
    logic [7:0]      rdata;
    logic [1:0]      pin_s1;
    logic [1:0]      pin_s2;
    logic [11:0][7:0] rf;
    logic [3:0]      act_rate;
    logic [6:0]      act_loss;
    logic            shift_neg;
    logic [6:0]      shift_mag;
  } core_s;

  core_s      q_r;
  core_s      q_nxt;
  logic       wr_open;
  logic [7:0] rd_val;
  logic [7:0] loss_sel;
  logic       serve;

  amp_xfer_if xf ();

  amp_link_port u_link (
    .i_link_clk   (i_link_clk),
    .i_link_nrst  (i_link_nrst),
    .i_xfer_valid (i_xfer_valid),
    .i_xfer_write (i_xfer_write),
    .i_xfer_addr  (i_xfer_addr),
    .i_xfer_wdata (i_xfer_wdata),
    .o_xfer_busy  (o_xfer_busy),
    .o_xfer_done  (o_xfer_done),
    .o_xfer_rdata (o_xfer_rdata),
    .xf           (xf.link)
  );

  ////////////////////////////////////////////////////////////////////////////

  // Bits outside the mask are never stored, so they read back zero
  function automatic logic [7:0] reg_mask(input logic [7:0] a);
    case (a)
      REG_CTRL:   reg_mask = MSK_CTRL;
      REG_THR:    reg_mask = MSK_THR;
      REG_PRE:    reg_mask = MSK_PRE;
      REG_RATE_C: reg_mask = MSK_RATE;
      REG_RATE_D: reg_mask = MSK_RATE;
      REG_LOSS_A: reg_mask = MSK_LOSS;
      REG_LOSS_B: reg_mask = MSK_LOSS;
      REG_LOSS_C: reg_mask = MSK_LOSS;
      REG_LOSS_D: reg_mask = MSK_LOSS;
      default:    reg_mask = MSK_NONE;
    endcase
  endfunction

  // Control stays writable, else a disabled interface could never recover
  assign wr_open = (xf.addr == REG_CTRL) || !q_r.rf[REG_CTRL][SIO_BIT];

  always_comb begin
    rd_val = MSK_NONE;
    if (xf.addr < 8'(NUM_RF)) begin
      rd_val = q_r.rf[xf.addr[3:0]] & reg_mask(xf.addr);
    end else if (xf.addr == REG_ACT_RATE) begin
      rd_val = {4'h0, q_r.act_rate};
    end else if (xf.addr == REG_ACT_LOSS) begin
      rd_val = {1'b0, q_r.act_loss};
    end
  end

  // Pin pair picks which loss register is consulted
  always_comb begin
    case (q_r.pin_s2)
      PIN_A:   loss_sel = REG_LOSS_A;
      PIN_B:   loss_sel = REG_LOSS_B;
      PIN_C:   loss_sel = REG_LOSS_C;
      default: loss_sel = REG_LOSS_D;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    q_nxt        = q_r;
    q_nxt.req_s1 = xf.req_tgl;
    q_nxt.req_s2 = q_r.req_s1;
    q_nxt.pin_s1 = {i_rate_pin_high, i_rate_pin_low};
    q_nxt.pin_s2 = q_r.pin_s1;
    case (q_r.st)
      ST_IDLE: begin
        if (q_r.req_s2 != q_r.req_seen) begin
          q_nxt.req_seen = q_r.req_s2;
          q_nxt.st       = ST_SERVE;
        end
      end
      ST_SERVE: begin
        // Link words are frozen until the ack toggle returns
        if (xf.write) begin
          for (int i = 0; i < NUM_RF; i++) begin
            if (xf.addr == 8'(i) && wr_open) begin
              q_nxt.rf[i] = xf.wdata & reg_mask(8'(i));
            end
          end
        end else begin
          q_nxt.rdata = rd_val;
        end
        q_nxt.ack = ~q_r.ack;
        q_nxt.st  = ST_IDLE;
      end
      default: begin
        q_nxt.st = ST_IDLE;
      end
    endcase
    // Rate code in effect
    case (q_r.pin_s2)
      PIN_C: begin
        q_nxt.act_rate = q_r.rf[REG_RATE_C][USE_BIT] ?
                         q_r.rf[REG_RATE_C][3:0] : DEF_RATE_C;
      end
      PIN_D: begin
        q_nxt.act_rate = q_r.rf[REG_RATE_D][USE_BIT] ?
                         q_r.rf[REG_RATE_D][3:0] : DEF_RATE_D;
      end
      PIN_B: begin
        q_nxt.act_rate = DEF_RATE_B;
      end
      default: begin
        q_nxt.act_rate = DEF_RATE_A;
      end
    endcase
    // Loss level in effect
    q_nxt.act_loss = q_r.rf[loss_sel][USE_BIT] ?
                     q_r.rf[loss_sel][6:0] : DEF_LOSS;
    // Threshold decode into sign and magnitude
    if (q_r.rf[REG_THR] == THR_ZERO) begin
      q_nxt.shift_neg = 1'b0;
      q_nxt.shift_mag = 7'h00;
    end else if (q_r.rf[REG_THR][7]) begin
      q_nxt.shift_neg = 1'b1;
      q_nxt.shift_mag = q_r.rf[REG_THR][6:0];
    end else if (q_r.rf[REG_THR] == THR_NONE) begin
      q_nxt.shift_neg = 1'b0;
      q_nxt.shift_mag = THR_MAX_MAG;
    end else begin
      q_nxt.shift_neg = 1'b0;
      q_nxt.shift_mag = 7'(THR_ZERO - q_r.rf[REG_THR]);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      q_r              <= '0;
      q_r.st           <= ST_IDLE;
      q_r.rf[REG_THR]  <= RST_THR;
    end else if (i_clk_en) begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign xf.ack_tgl              = q_r.ack;
  assign xf.rdata                = q_r.rdata;
  assign o_output_off_flag       = q_r.rf[REG_CTRL][OFF_BIT];
  assign o_detector_range_flag   = q_r.rf[REG_CTRL][RNG_BIT];
  assign o_offset_correction_off = q_r.rf[REG_CTRL][OCO_BIT];
  assign o_serial_interface_off  = q_r.rf[REG_CTRL][SIO_BIT];
  assign o_shift_negative        = q_r.shift_neg;
  assign o_shift_magnitude       = q_r.shift_mag;
  assign o_preemphasis_code      = q_r.rf[REG_PRE][3:0];
  assign o_active_rate_value     = q_r.act_rate;
  assign o_active_loss_value     = q_r.act_loss;
  assign serve                   = (q_r.st == ST_SERVE);

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst || !i_clk_en);

  sequence s_req_new;
    (q_r.st == ST_IDLE) && (q_r.req_s2 != q_r.req_seen);
  endsequence

  sequence s_served;
    ##1 serve ##1 ((q_r.st == ST_IDLE) && (q_r.ack != $past(q_r.ack, 2)));
  endsequence

  property p_serve_turn;
    s_req_new |-> s_served;
  endproperty
  a_serve_turn : assert property (p_serve_turn)
    else $error("request not answered within two cycles");

  property p_rate_c_write;
    (serve && xf.write && xf.addr == REG_RATE_C && wr_open)
      |=> q_r.rf[REG_RATE_C] == ($past(xf.wdata) & MSK_RATE);
  endproperty
  a_rate_c_write : assert property (p_rate_c_write)
    else $error("rate C write not stored with unused bits cleared");

  property p_rate_d_unused;
    q_r.rf[REG_RATE_D][6:4] == 3'h0;
  endproperty
  a_rate_d_unused : assert property (p_rate_d_unused)
    else $error("rate D unused bits not zero");

  property p_loss_b_write;
    (serve && xf.write && xf.addr == REG_LOSS_B && wr_open)
      |=> q_r.rf[REG_LOSS_B] == $past(xf.wdata);
  endproperty
  a_loss_b_write : assert property (p_loss_b_write)
    else $error("loss B write not stored");

  property p_rate_c_used;
    (q_r.pin_s2 == PIN_C && q_r.rf[REG_RATE_C][USE_BIT])
      |=> o_active_rate_value == $past(q_r.rf[REG_RATE_C][3:0]);
  endproperty
  a_rate_c_used : assert property (p_rate_c_used)
    else $error("rate C code not in effect with both pins high");

  property p_rate_c_default;
    (q_r.pin_s2 == PIN_C && !q_r.rf[REG_RATE_C][USE_BIT])
      |=> o_active_rate_value == DEF_RATE_C;
  endproperty
  a_rate_c_default : assert property (p_rate_c_default)
    else $error("rate C default not applied");

  property p_loss_c_used;
    (q_r.pin_s2 == PIN_C && q_r.rf[REG_LOSS_C][USE_BIT])
      |=> o_active_loss_value == $past(q_r.rf[REG_LOSS_C][6:0]);
  endproperty
  a_loss_c_used : assert property (p_loss_c_used)
    else $error("loss C level not in effect");

  property p_loss_read;
    (serve && !xf.write && xf.addr == REG_ACT_LOSS)
      |=> q_r.rdata == {1'b0, $past(q_r.act_loss)};
  endproperty
  a_loss_read : assert property (p_loss_read)
    else $error("loss status read wrong");

  property p_ro_write;
    (serve && xf.write && xf.addr > REG_LOSS_D) |=> $stable(q_r.rf);
  endproperty
  a_ro_write : assert property (p_ro_write)
    else $error("write to unmapped or read-only offset changed state");

  property p_sio_block;
    (serve && xf.write && xf.addr != REG_CTRL && o_serial_interface_off)
      |=> $stable(q_r.rf);
  endproperty
  a_sio_block : assert property (p_sio_block)
    else $error("write accepted while serial interface off");

  property p_ctrl_write;
    (serve && xf.write && xf.addr == REG_CTRL)
      |=> (o_detector_range_flag == $past(xf.wdata[RNG_BIT]))
          && (o_output_off_flag == $past(xf.wdata[OFF_BIT]));
  endproperty
  a_ctrl_write : assert property (p_ctrl_write)
    else $error("control flags not taken from write");

  property p_thr_decode;
    (q_r.rf[REG_THR] == THR_ZERO) |=> (!o_shift_negative && o_shift_magnitude == 7'h00);
  endproperty
  a_thr_decode : assert property (p_thr_decode)
    else $error("code 128 did not give zero shift");

  property p_thr_pos;
    (q_r.rf[REG_THR] == 8'h01) |=> (!o_shift_negative && o_shift_magnitude == THR_MAX_MAG);
  endproperty
  a_thr_pos : assert property (p_thr_pos)
    else $error("code 1 did not give maximum positive shift");

  property p_pre_write;
    (serve && xf.write && xf.addr == REG_PRE && wr_open)
      |=> (o_preemphasis_code == $past(xf.wdata[3:0])) && (q_r.rf[REG_PRE][7:4] == 4'h0);
  endproperty
  a_pre_write : assert property (p_pre_write)
    else $error("preemphasis write wrong");
endmodule

// file: amp_link_master.sv
`timescale 1ns/1ps
module amp_link_master
  import amp_cfg_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = 7'b1000100
) (
  input  wire logic       i_link_clk,
  input  wire logic       i_xfer_busy,
  input  wire logic       i_xfer_done,
  input  wire logic [7:0] i_xfer_rdata,
  output logic            o_xfer_valid,
  output logic            o_xfer_write,
  output logic [7:0]      o_xfer_addr,
  output logic [7:0]      o_xfer_wdata
);
  // Idle link cycles before each request, to act slow
  int gap = 0;
  initial begin
    o_xfer_valid = 1'b0;
    o_xfer_write = 1'b0;
    o_xfer_addr  = 8'h00;
    o_xfer_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  // Released lines show the inverse, so stale data never passes
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge i_link_clk);
    repeat (gap) @(posedge i_link_clk);
    #1;
    while (i_xfer_busy !== 1'b0 && n < 64) begin
      @(posedge i_link_clk);
      #1;
      n++;
    end
    o_xfer_valid = 1'b1;
    o_xfer_write = w;
    o_xfer_addr  = a;
    o_xfer_wdata = d;
    @(posedge i_link_clk);
    #1;
    o_xfer_valid = 1'b0;
    o_xfer_write = ~w;
    o_xfer_addr  = ~a;
    o_xfer_wdata = ~d;
    n = 0;
    // Look just after the edge, where done and rdata have settled
    while (i_xfer_done !== 1'b1 && n < 64) begin
      @(posedge i_link_clk);
      #1;
      n++;
    end
    q = i_xfer_rdata;
  endtask
endmodule

// file: test_amp_config_register_bank.sv
`timescale 1ns/1ps
module test_amp_config_register_bank
  import amp_cfg_pkg::*;
  ;
  logic        sys_clk;
  logic        link_clk;
  logic        nrst;
  logic        link_nrst;
  logic        clk_en;
  logic [1:0]  pins;
  logic        valid;
  logic        write;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        busy;
  logic        done;
  logic [7:0]  rdata;
  logic [3:0]  ctrl_o;
  logic        neg;
  logic [6:0]  mag;
  logic [3:0]  pre;
  logic [3:0]  act_rate;
  logic [6:0]  act_loss;
  logic [7:0]  sh [16];
  logic [16:0] exp_q [$];
  logic [16:0] ent;
  int          errors;
  int          cmp_count;
  int          seed;

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Odd offset keeps the link clock out of phase with the core
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  amp_config_register_bank amp_config_register_bank_i (
    .i_sys_clk               (sys_clk),
    .i_nrst                  (nrst),
    .i_clk_en                (clk_en),
    .i_rate_pin_high         (pins[1]),
    .i_rate_pin_low          (pins[0]),
    .i_link_clk              (link_clk),
    .i_link_nrst             (link_nrst),
    .i_xfer_valid            (valid),
    .i_xfer_write            (write),
    .i_xfer_addr             (addr),
    .i_xfer_wdata            (wdata),
    .o_xfer_busy             (busy),
    .o_xfer_done             (done),
    .o_xfer_rdata            (rdata),
    .o_output_off_flag       (ctrl_o[3]),
    .o_detector_range_flag   (ctrl_o[2]),
    .o_offset_correction_off (ctrl_o[1]),
    .o_serial_interface_off  (ctrl_o[0]),
    .o_shift_negative        (neg),
    .o_shift_magnitude       (mag),
    .o_preemphasis_code      (pre),
    .o_active_rate_value     (act_rate),
    .o_active_loss_value     (act_loss)
  );

  amp_link_master amp_link_master_i (
    .i_link_clk   (link_clk),
    .i_xfer_busy  (busy),
    .i_xfer_done  (done),
    .i_xfer_rdata (rdata),
    .o_xfer_valid (valid),
    .o_xfer_write (write),
    .o_xfer_addr  (addr),
    .o_xfer_wdata (wdata)
  );
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error: %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    exp_q.push_back({1'b1, a, e});
    amp_link_master_i.xfer(1'b0, a, 8'h00, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] nv);
    logic [7:0] q;
    exp_q.push_back({1'b0, a, d});
    amp_link_master_i.xfer(1'b1, a, d, q);
    sh[a[3:0]] = nv;
  endtask
  function automatic logic [7:0] exp_rate(input logic [1:0] p);
    if (p == PIN_C)
      return sh[6][7] ? {4'h0, sh[6][3:0]} : {4'h0, DEF_RATE_C};
    if (p == PIN_D)
      return sh[7][7] ? {4'h0, sh[7][3:0]} : {4'h0, DEF_RATE_D};
    return {4'h0, (p == PIN_B) ? DEF_RATE_B : DEF_RATE_A};
  endfunction
  function automatic logic [7:0] exp_loss(input logic [1:0] p);
    logic [7:0] r;
    r = sh[(p == PIN_A) ? 8 : (p == PIN_B) ? 9 : (p == PIN_C) ? 10 : 11];
    return r[7] ? {1'b0, r[6:0]} : {1'b0, DEF_LOSS};
  endfunction
  task automatic end_of_test();
    // A lost transfer leaves its note behind
    if (exp_q.size() != 0) begin
      errors++;
      $display("Error: pending notes expected 0 seen %0d", exp_q.size());
    end
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Writes queue a note too, so every done pulse pops exactly one
  // Falling edge looks while the one-cycle done pulse stands settled
  always @(negedge link_clk) begin
    if (done === 1'b1) begin
      chk("busy", {7'h00, busy}, 8'h00);
      if (exp_q.size() == 0) begin
        errors++;
        $display("Error: rdata expected none seen %h", rdata);
      end else begin
        ent = exp_q.pop_front();
        if (ent[16])
          chk("rdata", rdata, ent[7:0]);
      end
    end
  end
  initial begin
    #400000;
    errors++;
    $display("Error: watchdog expected finish seen timeout");
    end_of_test();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [7:0] ad [8] = '{REG_RATE_C, REG_RATE_D, REG_LOSS_A, REG_LOSS_B,
                           REG_LOSS_C, REG_LOSS_D, REG_THR, REG_PRE};
    logic [7:0] mk [8] = '{MSK_RATE, MSK_RATE, MSK_LOSS, MSK_LOSS,
                           MSK_LOSS, MSK_LOSS, MSK_THR, MSK_PRE};
    logic [7:0] un [4] = '{8'h03, 8'h05, 8'h0C, 8'h0D};
    logic [7:0] th [6] = '{8'h01, 8'h7F, 8'h80, 8'h81, 8'hFF, 8'h00};
    logic [7:0] pe [3] = '{8'h00, 8'h01, 8'hF6};
    seed = 32'h01954FE3;
    errors = 0;
    cmp_count = 0;
    nrst = 1'b0;
    link_nrst = 1'b0;
    clk_en = 1'b1;
    pins = 2'b00;
    foreach (sh[i])
      sh[i] = 8'h00;
    sh[1] = RST_THR;
    repeat (16) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    link_nrst = 1'b1;
    repeat (4) @(posedge sys_clk);
    // Test 1: reset state
    chk("ctrl", {4'h0, ctrl_o}, 8'h00);
    chk("shift", {neg, mag}, 8'h00);
    rd(REG_CTRL, 8'h00);
    rd(REG_THR, RST_THR);
    $display("test 1 done");
    // Test 2: random data through every writable place except control, then holes
    for (int k = 0; k < 8; k++) begin
      d = 8'($random(seed));
      wr(ad[k], d, d & mk[k]);
      rd(ad[k], d & mk[k]);
    end
    foreach (un[k]) begin
      wr(un[k], 8'hFF, 8'h00);
      rd(un[k], 8'h00);
    end
    wr(REG_ACT_RATE, 8'hFF, 8'h00);
    wr(REG_ACT_LOSS, 8'hFF, 8'h00);
    $display("test 2 done");
    // Test 3: every pin code, with use flags as written and then flipped
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 6 && p == 1; k++)
        wr(ad[k], sh[ad[k][3:0]] ^ 8'h80, sh[ad[k][3:0]] ^ 8'h80);
      for (int q = 0; q < 4; q++) begin
        @(posedge sys_clk);
        #1;
        pins = 2'(q);
        repeat (6) @(posedge sys_clk);
        chk("act_rate", {4'h0, act_rate}, exp_rate(pins));
        chk("act_loss", {1'b0, act_loss}, exp_loss(pins));
        rd(REG_ACT_RATE, exp_rate(pins));
        rd(REG_ACT_LOSS, exp_loss(pins));
      end
    end
    // Frozen core keeps the values in effect although the pins move
    @(posedge sys_clk);
    #1;
    clk_en = 1'b0;
    pins = 2'b00;
    repeat (6) @(posedge sys_clk);
    chk("frozen_rate", {4'h0, act_rate}, exp_rate(2'b11));
    chk("frozen_loss", {1'b0, act_loss}, exp_loss(2'b11));
    #1;
    clk_en = 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("act_rate", {4'h0, act_rate}, exp_rate(pins));
    chk("act_loss", {1'b0, act_loss}, exp_loss(pins));
    $display("test 3 done");
    // Test 4: control flags one at a time, then interface off
    for (int j = 1; j < 4; j++) begin
      d = 8'h01 << j;
      wr(REG_CTRL, d | 8'hF0, d);
      chk("ctrl", {4'h0, ctrl_o}, d);
      rd(REG_CTRL, d);
    end
    wr(REG_CTRL, 8'h01, 8'h01);
    chk("ctrl", {4'h0, ctrl_o}, 8'h01);
    wr(REG_RATE_C, ~sh[6], sh[6]);
    rd(REG_RATE_C, sh[6]);
    wr(REG_CTRL, 8'h00, 8'h00);
    chk("ctrl", {4'h0, ctrl_o}, 8'h00);
    $display("test 4 done");
    // Test 5: threshold codes at each boundary, master now slow
    amp_link_master_i.gap = 3;
    foreach (th[k]) begin
      wr(REG_THR, th[k], th[k]);
      if (th[k] == THR_NONE)
        d = {1'b0, THR_MAX_MAG};
      else if (th[k] > THR_ZERO)
        d = (th[k] - THR_ZERO) | 8'h80;
      else
        d = THR_ZERO - th[k];
      chk("shift", {neg, mag}, d);
    end
    $display("test 5 done");
    // Test 6: preemphasis codes, upper nibble dropped
    foreach (pe[k]) begin
      wr(REG_PRE, pe[k], pe[k] & 8'h0F);
      chk("pre", {4'h0, pre}, pe[k] & 8'h0F);
    end
    $display("test 6 done");
    repeat (8) @(posedge link_clk);
    end_of_test();
  end
endmodule
